// file: src/port_bridge_pkg.sv
// Purpose: constants and types for the graphics port bridge
// Assumes: 32-bit axi4-lite register access, agp clock sampled by clk
// Notes: rule summary follows
//
// Function
// RULE1: serve normal and high priority requests to memory; never to hub.
// RULE2: pipelined and sideband memory accesses are not snooped.
// RULE3: frame protocol cycles always run at 1x; fast writes here run at the selected rate.
// RULE4: status reports quad-rate ability in rate capability bit 2.
// RULE5: rate bit 2 set at init gives 4x; rate then stays fixed.
// RULE6: 4x moves 16 bytes per clock; throttle block is 64 bytes.
// RULE7: 4x uses two data strobe complements and one sideband complement.
// RULE8: control signalling in 4x equals 1x and 2x; only strobing differs.
// RULE9: fast write only when control bit 1 and command bit 4 set.
// RULE10: capability enable resets 0; when set, status bit 4 reports support.
// RULE11: host and hub memory writes use fast write when both enabled; here a 2x or 4x rate with rate bit 0 clear is also needed.
// RULE12: rate bit 2 gives 4x, bit 1 2x; bit 0 gives plain 1x.
// RULE13: software sets exactly one of the three rate bits.
// RULE14: frame memory accesses are snooped; no lock or error signals.
// RULE15: the three memory read commands are identical; hub reads unclaimed.
// RULE16: memory write and write-invalidate are aliased and posted.
// RULE17: other frame commands are unclaimed so the master aborts.
// RULE18: locked target accesses not honoured; fast back-to-back accepted.
// RULE19: initiator issues read, read line, write only; no merge or back-to-back.
// RULE20: host io inside base-limit window goes to port; else to hub.
// RULE21: host config goes out as type 1; locked cycles go unlocked.
// RULE22: retried frame read becomes one delayed transaction capturing address, command.
// RULE23: master repeats read; device completes it then frees the slot.
package port_bridge_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_COMMAND = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_IO_BASE = 8'h0c;
    localparam logic [7:0] ADDR_IO_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_DELAYED = 8'h14;
    localparam int BIT_RATE_4X = 2;
    localparam int BIT_RATE_2X = 1;
    localparam int BIT_RATE_1X = 0;
    localparam int BIT_FW_STATUS = 4;
    localparam int BIT_FW_PROTOCOL = 4;
    localparam int BIT_FW_CAPABILITY = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // commands and rates
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_INTACK = 4'h0;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;
    localparam logic [4:0] BYTES_1X = 5'h04;
    localparam logic [4:0] BYTES_2X = 5'h08;
    localparam logic [4:0] BYTES_4X = 5'h10;
    localparam logic [6:0] BLOCK_CLOCKS = 7'h04;
    typedef enum logic [1:0] {
        RATE_1X = 2'b00,
        RATE_2X = 2'b01,
        RATE_4X = 2'b10
    } rate_t;
    typedef enum logic [1:0] {
        REQ_PIPE = 2'b00,
        REQ_SBA = 2'b01,
        REQ_FRAME = 2'b10
    } req_kind_t;
    typedef enum logic [1:0] {
        ANS_NONE = 2'b00,
        ANS_CLAIM = 2'b01,
        ANS_RETRY = 2'b10,
        ANS_DONE = 2'b11
    } answer_t;
    typedef struct packed {
        logic valid;
        req_kind_t kind;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic hub_hit;
        logic locked;
    } agp_req_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic high_prio;
        logic snoop;
        logic [31:0] addr;
    } mem_req_t;
    typedef struct packed {
        logic valid;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic locked;
        logic from_hub;
    } host_req_t;
    typedef struct packed {
        logic valid;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic fast_write;
        rate_t rate;
        logic cfg_type1;
        logic locked;
        logic to_hub;
    } out_cycle_t;
endpackage

// file: src/agp_port_bridge.sv
// Purpose: graphics port side of a host bridge
// Assumes: agp pins and agp clock come from outside and are synchronised
// Notes: a transaction-level view; pin timing is left to the phy
`timescale 1ns/1ps
module agp_port_bridge
    import port_bridge_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic agp_clk,
    input wire agp_req_t agp_req,
    input wire logic mem_rd_done,
    input wire host_req_t host_req,
    output mem_req_t mem_req,
    output answer_t agp_answer,
    output out_cycle_t out_cycle,
    output logic [4:0] bytes_per_clk,
    output logic [6:0] block_bytes,
    output logic [1:0] ad_strobe_comp_en,
    output logic sba_strobe_comp_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_STATUS) || (a == ADDR_COMMAND) ||
                 (a == ADDR_CONTROL) || (a == ADDR_IO_BASE) ||
                 (a == ADDR_IO_LIMIT) || (a == ADDR_DELAYED);
    endfunction

    function automatic logic is_mem_read(input logic [3:0] c);
        is_mem_read = (c == CMD_MEM_RD) || (c == CMD_MEM_RD_MULT) ||
                      (c == CMD_MEM_RD_LINE);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2:0] rate_sel;
    logic rate_locked;
    logic fast_write_protocol_enable;
    logic fast_write_capability_enable;
    logic [31:0] io_base;
    logic [31:0] io_limit;
    logic dt_pending;
    logic dt_ready;
    logic [31:0] dt_addr;
    logic [3:0] dt_cmd;
    logic fast_write_on;
    rate_t rate_mode;
    logic wr_go;
    logic [31:0] port_status_register;
    logic [31:0] port_command_register;
    logic [31:0] port_control_register;

    // 4x wins, then 2x; bit 0 or nothing means 1x [RULE5] [RULE12]
    always_comb
    begin
        if (rate_sel[BIT_RATE_4X])
            rate_mode = RATE_4X;
        else if (rate_sel[BIT_RATE_2X])
            rate_mode = RATE_2X;
        else
            rate_mode = RATE_1X;
    end

    // both enables and a strobed rate are needed [RULE9] [RULE12]
    assign fast_write_on = fast_write_capability_enable &&
                           fast_write_protocol_enable &&
                           !rate_sel[BIT_RATE_1X] &&
                           (rate_sel[BIT_RATE_4X] || rate_sel[BIT_RATE_2X]);

    always_comb
    begin
        port_status_register = 32'h0;
        port_status_register[BIT_RATE_4X] = 1'b1; // [RULE4]
        port_status_register[BIT_FW_STATUS] =
            fast_write_capability_enable; // [RULE10]
        port_command_register = 32'h0;
        port_command_register[2:0] = rate_sel;
        port_command_register[BIT_FW_PROTOCOL] = fast_write_protocol_enable;
        port_control_register = 32'h0;
        port_control_register[BIT_FW_CAPABILITY] =
            fast_write_capability_enable;
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    // address and data are taken together; simpler than buffering one
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rate_sel <= 3'h0;
            rate_locked <= 1'b0;
            fast_write_protocol_enable <= 1'b0;
            fast_write_capability_enable <= 1'b0; // [RULE10]
            io_base <= 32'h0;
            io_limit <= 32'h0;
        end
        else if (wr_go && s_axi_wstrb[0])
        begin
            case (s_axi_awaddr)
                ADDR_COMMAND:
                begin
                    // rate is taken once and never changes again [RULE5]
                    if (!rate_locked && (s_axi_wdata[2:0] != 3'h0))
                    begin
                        rate_sel <= s_axi_wdata[2:0];
                        rate_locked <= 1'b1;
                    end
                    fast_write_protocol_enable <=
                        s_axi_wdata[BIT_FW_PROTOCOL];
                end
                ADDR_CONTROL:
                    fast_write_capability_enable <=
                        s_axi_wdata[BIT_FW_CAPABILITY];
                ADDR_IO_BASE:
                    io_base <= s_axi_wdata;
                ADDR_IO_LIMIT:
                    io_limit <= s_axi_wdata;
                default:
                    rate_locked <= rate_locked;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                ADDR_STATUS: s_axi_rdata <= port_status_register;
                ADDR_COMMAND: s_axi_rdata <= port_command_register;
                ADDR_CONTROL: s_axi_rdata <= port_control_register;
                ADDR_IO_BASE: s_axi_rdata <= io_base;
                ADDR_IO_LIMIT: s_axi_rdata <= io_limit;
                ADDR_DELAYED: s_axi_rdata <= {30'h0, dt_ready, dt_pending};
                default: s_axi_rdata <= 32'h0;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // link sampling
    // ------------------------------------------------------------
    logic [1:0] agp_clk_sync;
    logic agp_clk_last;
    agp_req_t req_meta;
    agp_req_t req_sync;
    logic link_edge;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            agp_clk_sync <= 2'b00;
            agp_clk_last <= 1'b0;
            req_meta <= '0;
            req_sync <= '0;
        end
        else
        begin
            agp_clk_sync <= {agp_clk_sync[0], agp_clk};
            agp_clk_last <= agp_clk_sync[1];
            req_meta <= agp_req;
            req_sync <= req_meta;
        end
    end

    assign link_edge = agp_clk_sync[1] && !agp_clk_last;

    // ------------------------------------------------------------
    // target side
    // ------------------------------------------------------------
    logic take;
    logic is_frame;
    logic hp;
    logic rd_hit;

    assign take = link_edge && req_sync.valid;
    assign is_frame = (req_sync.kind == REQ_FRAME);
    assign hp = req_sync.cmd[0];
    assign rd_hit = dt_pending && (req_sync.addr == dt_addr) &&
                    (req_sync.cmd == dt_cmd);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_req <= '0;
            agp_answer <= ANS_NONE;
        end
        else
        begin
            mem_req <= '0;
            agp_answer <= ANS_NONE;
            if (take && !is_frame)
            begin
                // hub hits still go to memory, never out to the hub [RULE1]
                mem_req.valid <= 1'b1;
                mem_req.write <= req_sync.cmd[2];
                mem_req.high_prio <= hp; // [RULE1]
                mem_req.snoop <= 1'b0; // [RULE2]
                mem_req.addr <= req_sync.addr;
                agp_answer <= ANS_CLAIM;
            end
            else if (take && !req_sync.hub_hit)
            begin
                // lock is ignored; each frame is taken on its own [RULE18]
                if (req_sync.cmd == CMD_MEM_WR ||
                    req_sync.cmd == CMD_MEM_WR_INV)
                begin
                    mem_req.valid <= 1'b1; // [RULE16]
                    mem_req.write <= 1'b1;
                    mem_req.snoop <= 1'b1; // [RULE14]
                    mem_req.addr <= req_sync.addr;
                    agp_answer <= ANS_CLAIM;
                end
                else if (is_mem_read(req_sync.cmd)) // [RULE15]
                begin
                    if (rd_hit && dt_ready)
                        agp_answer <= ANS_DONE; // [RULE23]
                    else
                        agp_answer <= ANS_RETRY; // [RULE22]
                    if (!dt_pending)
                    begin
                        mem_req.valid <= 1'b1;
                        mem_req.snoop <= 1'b1; // [RULE14]
                        mem_req.addr <= req_sync.addr;
                    end
                end
            end
            // every other command stays unclaimed: master abort [RULE17]
        end
    end

    // ------------------------------------------------------------
    // delayed transaction slot
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dt_pending <= 1'b0;
            dt_ready <= 1'b0;
            dt_addr <= 32'h0;
            dt_cmd <= 4'h0;
        end
        else if (take && is_frame && !req_sync.hub_hit &&
                 is_mem_read(req_sync.cmd))
        begin
            if (!dt_pending)
            begin
                // a single slot; other reads retry until it frees [RULE22]
                dt_pending <= 1'b1;
                dt_ready <= 1'b0;
                dt_addr <= req_sync.addr;
                dt_cmd <= req_sync.cmd;
            end
            else if (rd_hit && dt_ready)
            begin
                dt_pending <= 1'b0; // [RULE23]
                dt_ready <= 1'b0;
            end
            else if (mem_rd_done)
                dt_ready <= 1'b1;
        end
        else if (dt_pending && mem_rd_done)
            dt_ready <= 1'b1;
    end

    // ------------------------------------------------------------
    // initiator side
    // ------------------------------------------------------------
    logic io_cmd;
    logic io_in_window;

    assign io_cmd = (host_req.cmd == CMD_IO_RD) ||
                    (host_req.cmd == CMD_IO_WR);
    assign io_in_window = (host_req.addr >= io_base) &&
                          (host_req.addr <= io_limit);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            out_cycle <= '0;
        else
        begin
            out_cycle <= '0;
            if (host_req.valid)
            begin
                out_cycle.valid <= 1'b1;
                out_cycle.addr <= host_req.addr;
                out_cycle.locked <= 1'b0; // [RULE21]
                out_cycle.rate <= RATE_1X; // [RULE3]
                out_cycle.cmd <= host_req.cmd;
                case (host_req.cmd)
                    CMD_MEM_WR, CMD_MEM_WR_INV:
                    begin
                        // each write goes alone, no merging [RULE19]
                        out_cycle.cmd <= CMD_MEM_WR;
                        out_cycle.fast_write <= fast_write_on; // [RULE11]
                        out_cycle.rate <= fast_write_on ?
                            rate_mode : RATE_1X; // [RULE12]
                    end
                    CMD_MEM_RD_MULT:
                        out_cycle.cmd <= CMD_MEM_RD_LINE; // [RULE19]
                    CMD_CFG_RD, CMD_CFG_WR:
                        out_cycle.cfg_type1 <= 1'b1; // [RULE21]
                    CMD_IO_RD, CMD_IO_WR:
                        out_cycle.to_hub <= !io_in_window; // [RULE20]
                    default:
                        out_cycle.cmd <= host_req.cmd;
                endcase
                if (host_req.from_hub && is_mem_read(host_req.cmd))
                    out_cycle.to_hub <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // data strobing
    // ------------------------------------------------------------
    // only strobes change with rate; control timing is untouched [RULE8]
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bytes_per_clk <= BYTES_1X;
            block_bytes <= 7'h0;
            ad_strobe_comp_en <= 2'b00;
            sba_strobe_comp_en <= 1'b0;
        end
        else
        begin
            case (rate_mode)
                RATE_4X: bytes_per_clk <= BYTES_4X; // [RULE6]
                RATE_2X: bytes_per_clk <= BYTES_2X;
                default: bytes_per_clk <= BYTES_1X;
            endcase
            block_bytes <= 7'((rate_mode == RATE_4X ? BYTES_4X :
                rate_mode == RATE_2X ? BYTES_2X : BYTES_1X) *
                BLOCK_CLOCKS); // [RULE6]
            ad_strobe_comp_en <= {2{rate_mode == RATE_4X}}; // [RULE7]
            sba_strobe_comp_en <= (rate_mode == RATE_4X); // [RULE7]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_NOSNOOP: assert property (take && !is_frame |=> mem_req.valid &&
        !mem_req.snoop) else $error("pipe request lost or snooped"); // [RULE2]
    AST_FRAME_1X: assert property (out_cycle.valid && !out_cycle.fast_write
        |-> out_cycle.rate == RATE_1X) else $error("frame not 1x"); // [RULE3]
    AST_CAP4X: assert property (port_status_register[BIT_RATE_4X])
        else $error("4x capability missing"); // [RULE4]
    AST_RATE_FIXED: assert property (rate_locked |=> $stable(rate_sel))
        else $error("rate changed"); // [RULE5]
    AST_BLOCK64: assert property (rate_mode == RATE_4X ##2 1 |->
        block_bytes == 7'h40) else $error("block not 64 bytes"); // [RULE6]
    AST_STROBES: assert property ($rose(rate_mode == RATE_4X) |=>
        ad_strobe_comp_en == 2'b11 && sba_strobe_comp_en)
        else $error("4x strobes off"); // [RULE7]
    AST_FW_GATE: assert property (out_cycle.fast_write |->
        $past(fast_write_capability_enable) &&
        $past(fast_write_protocol_enable)) else $error("fw gate"); // [RULE9]
    AST_FW_STATUS: assert property (fast_write_capability_enable ==
        port_status_register[BIT_FW_STATUS]) else $error("fw status"); // [RULE10]
    AST_ABORT: assert property (take && is_frame && (req_sync.cmd == CMD_IO_RD
        || req_sync.cmd == CMD_CFG_WR) |=> agp_answer == ANS_NONE)
        else $error("claimed unsupported command"); // [RULE17]
    AST_NO_RMULT: assert property (out_cycle.valid |-> out_cycle.cmd !=
        CMD_MEM_RD_MULT && out_cycle.cmd != CMD_MEM_WR_INV)
        else $error("bad initiator command"); // [RULE19]
    AST_UNLOCKED: assert property (host_req.valid |=> !out_cycle.locked)
        else $error("locked cycle issued"); // [RULE21]
    AST_ONE_DT: assert property (dt_pending && !(take && rd_hit && dt_ready)
        |=> dt_pending && $stable(dt_addr)) else $error("slot lost"); // [RULE22]

    COV_DT_DONE: cover property (agp_answer == ANS_RETRY ##[1:200]
        agp_answer == ANS_DONE);
    COV_FW4X: cover property (out_cycle.fast_write &&
        out_cycle.rate == RATE_4X);
    COV_IO_HUB: cover property (out_cycle.valid && out_cycle.to_hub);
endmodule

// file: test/gfx_master_model.sv
// Purpose: graphics master model driving link requests
// Assumes: free-running 48 ns link clock
// Notes: each request spans exactly one rising link edge
`timescale 1ns/1ps
module gfx_master_model
    import port_bridge_pkg::*;
(
    output logic agp_clk,
    output agp_req_t agp_req
);
    initial
    begin
        agp_clk = 1'b0;
        agp_req = '0;
        forever #24 agp_clk = ~agp_clk;
    end
    // one request per link period; a retry reuses address and command
    task automatic send(input agp_req_t r);
        @(negedge agp_clk);
        agp_req <= r;
        @(negedge agp_clk);
        // released lines show the inverse so stale values never match
        agp_req <= {1'b0, ~r[$bits(agp_req_t)-2:0]};
    endtask
endmodule

// file: test/test_agp_port_bridge.sv
// Purpose: self-checking bench for the graphics port bridge
// Assumes: axi4-lite master tasks, link model in its own file
// Notes: timeout counter guards every wait
`timescale 1ns/1ps
module test_agp_port_bridge;
    import port_bridge_pkg::*;
    logic clk, rst_b, agp_clk, mem_rd_done, sba_strobe_comp_en;
    agp_req_t agp_req;
    host_req_t host_req;
    mem_req_t mem_req, sm;
    answer_t agp_answer, sa;
    out_cycle_t out_cycle, so;
    logic [4:0] bytes_per_clk;
    logic [6:0] block_bytes;
    logic [1:0] ad_strobe_comp_en, s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    logic [3:0] bad[6] = '{4'h0, 4'h2, 4'h3, 4'ha, 4'hb, 4'hd};
    logic [3:0] rdc[3] = '{CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE};
    agp_port_bridge agp_port_bridge_i (.clk, .rst_b, .agp_clk, .agp_req,
        .mem_rd_done, .host_req, .mem_req, .agp_answer, .out_cycle,
        .bytes_per_clk, .block_bytes, .ad_strobe_comp_en,
        .sba_strobe_comp_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    gfx_master_model gfx_master_model_i (.agp_clk, .agp_req);
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // pulses last one cycle, so the monitor keeps the last one seen
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (agp_answer !== ANS_NONE) sa <= agp_answer;
        if (mem_req.valid === 1'b1) sm <= mem_req;
        if (out_cycle.valid === 1'b1) so <= out_cycle;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        {rd, rr} = {s_axi_rdata, s_axi_rresp};
    endtask
    task automatic host(input logic [3:0] c, input logic [31:0] a);
        @(posedge clk);
        host_req <= {1'b1, c, a, 2'h2};
        so <= '0;
        @(posedge clk);
        host_req <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic link(input req_kind_t k, input logic [3:0] c,
        input logic [31:0] a, input logic hub, input answer_t ea,
        input logic em);
        @(posedge clk);
        sa <= ANS_NONE;
        sm <= '0;
        gfx_master_model_i.send({1'b1, k, c, a, hub, 1'b0});
        repeat (12) @(posedge clk);
        chk("answer", sa, ea);
        chk("mem request", sm.valid, em);
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        {rst_b, mem_rd_done, host_req} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        axi_rd(ADDR_STATUS);
        chk("4x cap", rd[BIT_RATE_4X], 1'b1);
        chk("fw status", rd[BIT_FW_STATUS], 1'b0);
        axi_rd(8'h3c);
        chk("unmapped", rr, RESP_SLVERR);
        axi_wr(ADDR_COMMAND, 32'h14); // single rate bit
        host(CMD_MEM_WR, 32'h100);
        chk("fw off", so.fast_write, 1'b0);
        axi_wr(ADDR_CONTROL, 32'h2);
        axi_rd(ADDR_STATUS);
        chk("fw status", rd[BIT_FW_STATUS], 1'b1);
        axi_wr(ADDR_COMMAND, 32'h12);
        chk("bytes", bytes_per_clk, BYTES_4X);
        chk("block", block_bytes, 7'h40);
        chk("strobes", {ad_strobe_comp_en, sba_strobe_comp_en}, 3'h7);
        $display("test registers done");
        host(CMD_MEM_WR_INV, 32'h200);
        chk("wr cmd", so.cmd, CMD_MEM_WR);
        chk("fw", {so.fast_write, so.rate}, {1'b1, RATE_4X});
        chk("unlocked", so.locked, 1'b0);
        host(CMD_MEM_RD_MULT, 32'h300);
        chk("rd cmd", so.cmd, CMD_MEM_RD_LINE);
        host(CMD_CFG_RD, 32'h400);
        chk("type1", so.cfg_type1, 1'b1);
        axi_wr(ADDR_IO_BASE, 32'h1000);
        axi_wr(ADDR_IO_LIMIT, 32'h1fff);
        host(CMD_IO_RD, 32'h1fff);
        chk("io in", so.to_hub, 1'b0);
        host(CMD_IO_WR, 32'h2000);
        chk("io out", so.to_hub, 1'b1);
        $display("test host done");
        link(REQ_PIPE, 4'h5, 32'h40, 1'b1, ANS_CLAIM, 1'b1);
        chk("pipe", {sm.write, sm.high_prio, sm.snoop}, 3'h6);
        link(REQ_SBA, 4'h0, 32'h80, 1'b0, ANS_CLAIM, 1'b1);
        chk("sba snoop", sm.snoop, 1'b0);
        link(REQ_FRAME, CMD_MEM_WR_INV, 32'hc0, 1'b0, ANS_CLAIM, 1'b1);
        chk("frame wr", {sm.write, sm.snoop}, 2'h3);
        foreach (bad[i]) link(REQ_FRAME, bad[i], 32'h0, 1'b0, ANS_NONE, 1'b0);
        link(REQ_FRAME, CMD_MEM_RD, 32'h0, 1'b1, ANS_NONE, 1'b0);
        $display("test link done");
        foreach (rdc[i])
        begin
            link(REQ_FRAME, rdc[i], 32'h200, 1'b0, ANS_RETRY, 1'b1);
            chk("rd snoop", sm.snoop, 1'b1);
            link(REQ_FRAME, rdc[i], 32'h300, 1'b0, ANS_RETRY, 1'b0);
            @(posedge clk);
            mem_rd_done <= 1'b1;
            @(posedge clk);
            mem_rd_done <= 1'b0;
            link(REQ_FRAME, rdc[i], 32'h200, 1'b0, ANS_DONE, 1'b0);
        end
        axi_rd(ADDR_DELAYED);
        chk("slot free", rd[1:0], 2'h0);
        $display("test delayed done");
        give_verdict();
    end
endmodule
